// ==== rtl/scanned_discrete_input_port.sv ====
`timescale 1ns/1ps
module scanned_discrete_input_port
	import scan_input_pkg::*;
#(
	parameter int WATCHDOG_LIMIT = WATCHDOG_CYCLES,
	parameter int BLINK_LIMIT = BLINK_HALF_CYCLES
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [4:0] moduleAddr,
	input wire scan_req_type scanReq,
	input wire logic [15:0] channelIn,
	output scan_rsp_type scanRsp,
	output logic [15:0] channelLed,
	output logic activeLed
);

	logic [15:0] sync1_q;
	logic [15:0] sync2_q;
	logic [15:0] sync1_d;
	logic [15:0] sync2_d;
	logic [15:0] latch_q;
	logic [15:0] latch_d;
	scan_rsp_type rsp_q;
	scan_rsp_type rsp_d;
	logic [15:0] led_q;
	logic [15:0] led_d;
	logic [25:0] wdog_q;
	logic [25:0] wdog_d;
	logic [25:0] blink_q;
	logic [25:0] blink_d;
	logic phase_q;
	logic phase_d;
	logic act_q;
	logic act_d;
	act_state_type state_q;
	act_state_type state_d;
	logic hit;
	logic wdogExpired;
	logic blinkExpired;

	// True when a strobe names this port's address, which must be in range
	function automatic logic addr_match(input logic [4:0] a, input logic [4:0] own);
		addr_match = (a == own) && (own <= ADDR_MAX);
	endfunction : addr_match

	assign hit = scanReq.strobe && addr_match(scanReq.addr, moduleAddr);


	// True once a count has reached the last cycle of its period
	function automatic logic count_done(input logic [25:0] count, input int limit);
		count_done = (count >= 26'(limit - 1));
	endfunction : count_done

	// One step of a cycle counter
	function automatic logic [25:0] count_step(input logic [25:0] count);
		count_step = count + 26'h0000001;
	endfunction : count_step

	// Ends of the watchdog period and of each blink half period
	assign wdogExpired = count_done(wdog_q, WATCHDOG_LIMIT);
	assign blinkExpired = count_done(blink_q, BLINK_LIMIT);

	// First synchroniser stage for the asynchronous channel pins
	always_comb begin
		sync1_d = channelIn;
	end

	// Registers of the first stage
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sync1_q <= WORD_RESET;
		end else begin
			sync1_q <= sync1_d;
		end
	end

	// Second synchroniser stage, the only reader of the first
	always_comb begin
		sync2_d = sync1_q;
	end

	// Registers of the second stage
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sync2_q <= WORD_RESET;
		end else begin
			sync2_q <= sync2_d;
		end
	end

	// Latch of the settled channel states, read by the scan answer
	always_comb begin
		latch_d = sync2_q;
	end

	// Registers of the latch
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			latch_q <= WORD_RESET;
		end else begin
			latch_q <= latch_d;
		end
	end

	// Per-channel indicators follow the settled inputs
	always_comb begin
		led_d = sync2_q;
	end

	// Registers of the channel indicators
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			led_q <= WORD_RESET;
		end else begin
			led_q <= led_d;
		end
	end

	// Scan answer: valid for one cycle, word held until the next scan
	always_comb begin
		rsp_d.valid = hit;
		rsp_d.data = rsp_q.data;
		if (hit) begin
			rsp_d.data = latch_q;
		end
	end

	// Registers of the scan answer
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rsp_q <= RSP_RESET;
		end else begin
			rsp_q <= rsp_d;
		end
	end

	// Scan watchdog: counts idle cycles while steady, cleared by a taken scan
	always_comb begin
		wdog_d = COUNT_ZERO;
		if (state_q == ACT_STEADY && !hit && !wdogExpired) begin
			wdog_d = count_step(wdog_q);
		end
	end

	// Registers of the scan watchdog
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wdog_q <= COUNT_ZERO;
		end else begin
			wdog_q <= wdog_d;
		end
	end

	// Blink timer: idle while steady, flips the phase every half period
	always_comb begin
		blink_d = blink_q;
		phase_d = phase_q;
		if (state_q == ACT_STEADY) begin
			blink_d = COUNT_ZERO;
			phase_d = PHASE_RESET;
		end else if (blinkExpired) begin
			blink_d = COUNT_ZERO;
			phase_d = !phase_q;
		end else begin
			blink_d = count_step(blink_q);
		end
	end

	// Registers of the blink timer
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			blink_q <= COUNT_ZERO;
			phase_q <= PHASE_RESET;
		end else begin
			blink_q <= blink_d;
			phase_q <= phase_d;
		end
	end

	// Activity state: steady while scanned, blinking after a silent period
	always_comb begin
		state_d = state_q;
		act_d = act_q;
		case (state_q)
			ACT_STEADY: begin
				act_d = 1'b1;
				if (!hit && wdogExpired) begin
					state_d = ACT_BLINK;
					act_d = 1'b0;
				end
			end
			ACT_BLINK: begin
				if (hit) begin
					state_d = ACT_STEADY;
					act_d = 1'b1;
				end else if (blinkExpired) begin
					act_d = !phase_q;
				end
			end
			default: begin
				state_d = ACT_STEADY;
				act_d = 1'b1;
			end
		endcase
	end

	// Registers of the activity state and indicator
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			act_q <= ACT_RESET;
			state_q <= ACT_STEADY;
		end else begin
			act_q <= act_d;
			state_q <= state_d;
		end
	end

	// Outputs straight from their registers
	assign scanRsp = rsp_q;
	assign channelLed = led_q;
	assign activeLed = act_q;

endmodule : scanned_discrete_input_port

// ==== include/scan_input_pkg.sv ====
package scan_input_pkg;

	// Channel count and word layout
	localparam int CHANNEL_COUNT = 16;
	localparam int ADDR_WIDTH = 5;
	localparam logic [4:0] ADDR_MAX = 5'h1f;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	// Clock rate, watchdog and blink timing
	localparam int CLOCK_HZ = 50000000;
	localparam int WATCHDOG_MS = 700;
	localparam int WATCHDOG_CYCLES = (CLOCK_HZ / 1000) * WATCHDOG_MS;
	localparam int BLINK_HALF_MS = 500;
	localparam int BLINK_HALF_CYCLES = (CLOCK_HZ / 1000) * BLINK_HALF_MS;
	localparam logic [25:0] COUNT_ZERO = 26'h0000000;

	// One scan request and its answer
	typedef struct packed {
		logic strobe;
		logic [4:0] addr;
	} scan_req_type;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} scan_rsp_type;

	typedef enum logic [1:0] {
		ACT_STEADY = 2'b01,
		ACT_BLINK = 2'b10
	} act_state_type;

	// Values after reset
	localparam scan_rsp_type RSP_RESET = '0;
	localparam logic ACT_RESET = 1'b1;
	localparam logic PHASE_RESET = 1'b0;

endpackage : scan_input_pkg

// ==== verification/scan_chk_properties.sv ====
`timescale 1ns/1ps
module scan_chk
	import scan_input_pkg::*;
#(parameter int WATCHDOG_LIMIT = 20, parameter int BLINK_LIMIT = 4) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [4:0] moduleAddr,
	input wire scan_req_type scanReq,
	input wire logic [15:0] channelIn,
	input wire scan_rsp_type scanRsp,
	input wire logic [15:0] channelLed,
	input wire logic activeLed
);
	logic hit;
	int idle_q;
	int idle_d;
	// Cycles since the last taken scan
	assign hit = scanReq.strobe && scanReq.addr == moduleAddr;
	assign idle_d = hit ? 0 : idle_q + 1;
	always_ff @(posedge mclk or negedge nrst) idle_q <= !nrst ? 0 : idle_d;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	scan_answer_a: assert property (hit |=> scanRsp.valid)
		else $error("no answer");
	stray_answer_a: assert property (!hit |=> !scanRsp.valid)
		else $error("stray answer");
	word_hold_a: assert property (!scanRsp.valid |-> $stable(scanRsp.data))
		else $error("drift");
	word_content_a: assert property (
		$stable(channelIn)[*5] ##0 hit |=> scanRsp.data == $past(channelIn))
		else $error("bad word");
	channel_led_a: assert property ($stable(channelIn)[*5] |-> channelLed == channelIn)
		else $error("led");
	steady_active_a: assert property (idle_q < WATCHDOG_LIMIT - 1 |-> activeLed)
		else $error("dark");
	blink_off_a: assert property (
		idle_q inside {[WATCHDOG_LIMIT + 1 : WATCHDOG_LIMIT + BLINK_LIMIT - 1]} |-> !activeLed)
		else $error("no blink");
	blink_on_a: assert property (
		idle_q == WATCHDOG_LIMIT + BLINK_LIMIT + 2 |-> activeLed)
		else $error("no toggle");
	cover property (hit);
	cover property (scanReq.strobe && !hit);
	cover property ($fell(activeLed));
endmodule : scan_chk

// ==== verification/scan_unit.sv ====
`timescale 1ns/1ps
module scan_unit
	import scan_input_pkg::*;
(
	input wire logic mclk,
	input wire logic go,
	input wire logic [4:0] addr,
	output scan_req_type scanReq
);
	// One strobe per request, address lines toggle while idle
	initial scanReq = '0;
	always @(posedge mclk) scanReq <= '{go, go ? addr : ~scanReq.addr};
endmodule : scan_unit

// ==== verification/scanned_discrete_input_port_bench.sv ====
`timescale 1ns/1ps
module scanned_discrete_input_port_bench;
	import scan_input_pkg::*;
	logic mclk = 0, nrst = 0, go = 0, activeLed;
	logic [4:0] addr = 5'h00, moduleAddr = 5'h1f;
	logic [15:0] channelIn = 16'h0000, channelLed;
	logic [16:0] r;
	scan_req_type scanReq;
	scan_rsp_type scanRsp;
	int miscompares = 0, compares = 0;
	always #10 mclk = ~mclk;
	scan_unit scan_unit_inst (.mclk(mclk), .go(go), .addr(addr), .scanReq(scanReq));
	scanned_discrete_input_port #(.WATCHDOG_LIMIT(20), .BLINK_LIMIT(4))
		scanned_discrete_input_port_inst (.mclk(mclk), .nrst(nrst), .moduleAddr(moduleAddr),
		.scanReq(scanReq), .channelIn(channelIn), .scanRsp(scanRsp),
		.channelLed(channelLed), .activeLed(activeLed));
	task chk(input logic [16:0] e, input logic [16:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk
	task give_verdict;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	// Scan one address, answer word lands in r, zero when unanswered
	task scan(input logic [4:0] a);
		@(posedge mclk) {go, addr} <= {1'b1, a};
		@(posedge mclk) go <= 0;
		r = '0;
		repeat (3) begin
			@(posedge mclk) #1 if (scanRsp.valid) r = scanRsp;
		end
	endtask : scan
	task addr_test;
		scan(5'h1e);
		chk(17'h00000, r);
		scan(5'h1f);
		chk(17'h10000, r);
	endtask : addr_test
	task map_test;
		for (int i = 0; i < CHANNEL_COUNT; i++) begin
			@(posedge mclk) channelIn <= 16'h0001 << i;
			repeat (4) @(posedge mclk);
			#1 chk(17'h00001 << i, {1'b0, channelLed});
			scan(moduleAddr);
			chk(17'h10000 | (17'h00001 << i), r);
		end
	endtask : map_test
	task watch_test;
		repeat (19) @(posedge mclk);
		#1 chk(17'h00000, {16'h0000, activeLed});
		repeat (3) @(posedge mclk);
		#1 chk(17'h00001, {16'h0000, activeLed});
		repeat (3) @(posedge mclk);
		scan(moduleAddr);
		// Steady again for longer than a blink half period
		repeat (8) begin
			@(posedge mclk) #1 chk(17'h00001, {16'h0000, activeLed});
		end
	endtask : watch_test
	initial begin
		repeat (2) @(posedge mclk);
		nrst <= 1;
		addr_test;
		map_test;
		watch_test;
		give_verdict;
	end
	// Cut a hang short
	initial begin
		#1000000;
		miscompares++;
		give_verdict;
	end
endmodule : scanned_discrete_input_port_bench
bind scanned_discrete_input_port scan_chk #(.WATCHDOG_LIMIT(WATCHDOG_LIMIT),
	.BLINK_LIMIT(BLINK_LIMIT)) scan_chk_inst (.mclk(mclk), .nrst(nrst),
	.moduleAddr(moduleAddr), .scanReq(scanReq), .channelIn(channelIn),
	.scanRsp(scanRsp), .channelLed(channelLed), .activeLed(activeLed));
